/* shared/lgps_pkg.sv */
// constants for the lamp / general-purpose pin select block
package lgps_pkg;

	// ==========================================================
	// register byte addresses
	localparam logic [7:0] LGPS_ADDR_LAMP_CFG  = 8'h00;
	localparam logic [7:0] LGPS_ADDR_GPIO_CFG  = 8'h04;
	localparam logic [7:0] LGPS_ADDR_GPIO_DATA = 8'h08;
	localparam logic [7:0] LGPS_ADDR_STATUS    = 8'h0C;
	localparam logic [7:0] LGPS_ADDR_XOVER     = 8'h10;

	// ==========================================================
	// field positions
	localparam int LGPS_LAMP1_EN_BIT   = 1;
	localparam int LGPS_LAMP_FUN_LSB   = 8;
	localparam int LGPS_GENERAL_IO_PIN_1_OD_BIT   = 1;
	localparam int LGPS_GENERAL_IO_PIN_1_DATA_BIT = 1;
	localparam int LGPS_GENERAL_IO_PIN_1_DIR_BIT  = 9;
	localparam int LGPS_STAT_STRAP_BIT = 0;
	localparam int LGPS_STAT_PIN_BIT   = 1;
	localparam int LGPS_STAT_MODE_BIT  = 2;
	localparam int LGPS_XOVER_EN_BIT   = 0;

	// ==========================================================
	// encodings and reset values
	localparam logic [1:0]  LGPS_FUN_PUSH_PULL = 2'h0;
	localparam logic [1:0]  LGPS_FUN_RESET     = 2'h0;
	localparam logic [1:0]  LGPS_RESP_OKAY     = 2'h0;
	localparam logic [1:0]  LGPS_RESP_SLVERR   = 2'h2;
	localparam logic [31:0] LGPS_WORD_ZERO     = 32'h0000_0000;

endpackage : lgps_pkg

/* verilog/lgps_pin_driver.sv */
// registered output stage of the shared lamp / general-purpose pin
`timescale 1ns/1ps
module lgps_pin_driver
	import lgps_pkg::*;
(
	input  wire logic       aclk,        // clock
	input  wire logic       aresetn,     // synchronous reset, active low
	input  wire logic       lamp_mode,   // pin belongs to the lamp function
	input  wire logic [1:0] lamp_fun,    // lamp driver function field
	input  wire logic       strap,       // polarity strap captured at reset
	input  wire logic       lamp_on,     // lamp event level
	input  wire logic       gpio_dir,    // 1 = general-purpose output
	input  wire logic       gpio_od,     // 1 = open-drain output
	input  wire logic       gpio_data,   // general-purpose output value
	output logic            pin_out,     // pin output value
	output logic            pin_oe       // pin output enable, high = driving
);

	logic pin_out_next;
	logic pin_oe_next;

	// ==========================================================
	// function selection
	always_comb
	begin
		pin_out_next = 1'b0;
		pin_oe_next  = 1'b0;
		if (lamp_mode)
		begin
			if (lamp_fun == LGPS_FUN_PUSH_PULL)
			begin
				pin_out_next = lamp_on;
				pin_oe_next  = 1'b1;
			end
			else
			begin
				// open-source when strap is 0, open-drain when 1
				pin_out_next = ~strap;
				pin_oe_next  = lamp_on;
			end
		end
		else if (gpio_dir)
		begin
			pin_out_next = gpio_od ? 1'b0 : gpio_data;
			pin_oe_next  = gpio_od ? ~gpio_data : 1'b1;
		end
	end

	// ==========================================================
	// output flops, released while in reset so the strap can be read
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pin_out <= 1'b0;
			pin_oe  <= 1'b0;
		end
		else
		begin
			pin_out <= pin_out_next;
			pin_oe  <= pin_oe_next;
		end
	end

endmodule : lgps_pin_driver

/* verilog/lgps_pin_select.sv */
// shared pin select between status lamp 1 and general-purpose pin 1
// Contract
// - lamp enable set routes pin to lamp
// - lamp enable clear routes pin to gpio
// - function field picks push-pull or open-drain/source
// - open lamp polarity from captured strap only
// - strap 0 active high, 1 active low
// - gpio push-pull, open-drain or input by software
// - strap sets port 2 crossover default
// - strap latched at reset, eeprom may override
`timescale 1ns/1ps
module lgps_pin_select
	import lgps_pkg::*;
(
	input  wire logic        aclk,                   // clock, 200 MHz
	input  wire logic        aresetn,                // synchronous reset, active low
	input  wire logic [7:0]  s_axi_awaddr,           // write address
	input  wire logic        s_axi_awvalid,          // write address valid
	output logic             s_axi_awready,          // write address ready
	input  wire logic [31:0] s_axi_wdata,            // write data
	input  wire logic [3:0]  s_axi_wstrb,            // write byte strobes
	input  wire logic        s_axi_wvalid,           // write data valid
	output logic             s_axi_wready,           // write data ready
	output logic [1:0]       s_axi_bresp,            // write response
	output logic             s_axi_bvalid,           // write response valid
	input  wire logic        s_axi_bready,           // write response ready
	input  wire logic [7:0]  s_axi_araddr,           // read address
	input  wire logic        s_axi_arvalid,          // read address valid
	output logic             s_axi_arready,          // read address ready
	output logic [31:0]      s_axi_rdata,            // read data
	output logic [1:0]       s_axi_rresp,            // read response
	output logic             s_axi_rvalid,           // read data valid
	input  wire logic        s_axi_rready,           // read data ready
	input  wire logic        lamp_activity,          // lamp event level from port logic
	input  wire logic        strap_override_valid,   // eeprom loader replaces strap, pulse
	input  wire logic        strap_override_value,   // replacement strap value
	input  wire logic        status_lamp_pin_1_in,   // pin level as seen at the pad
	output logic             status_lamp_pin_1_out,  // pin output value
	output logic             status_lamp_pin_1_oe,   // pin output enable, high = driving
	output logic             port2_crossover_enable  // port 2 automatic crossover soft-strap
);

	logic        pin_meta_reg;
	logic        pin_sync_reg;
	logic        port2_crossover_polarity_strap;
	logic        lamp_en_reg;
	logic [1:0]  lamp_driver_function_field;
	logic        gpio_od_reg;
	logic        gpio_data_reg;
	logic        gpio_dir_reg;
	logic [7:0]  wr_addr_reg;
	logic [31:0] wr_data_reg;
	logic [3:0]  wr_strb_reg;
	logic        aw_held_reg;
	logic        w_held_reg;
	logic        wr_go;
	logic        wr_hit;
	logic        rd_hit;
	logic [31:0] rd_word;

	// ==========================================================
	// pad input synchroniser
	always_ff @(posedge aclk)
	begin
		pin_meta_reg <= status_lamp_pin_1_in;
		pin_sync_reg <= pin_meta_reg;
	end

	// ==========================================================
	// strap capture: follows the pad during reset, frozen at release, changed after that only by an eeprom override
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			port2_crossover_polarity_strap <= pin_sync_reg;
		else if (strap_override_valid)
			port2_crossover_polarity_strap <= strap_override_value;
	end

	// ==========================================================
	// write channel
	assign wr_go  = aw_held_reg && w_held_reg && !s_axi_bvalid;
	assign wr_hit = (wr_addr_reg == LGPS_ADDR_LAMP_CFG) || (wr_addr_reg == LGPS_ADDR_GPIO_CFG)
		|| (wr_addr_reg == LGPS_ADDR_GPIO_DATA) || (wr_addr_reg == LGPS_ADDR_XOVER);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_reg <= 1'b0;
			w_held_reg  <= 1'b0;
			wr_addr_reg <= LGPS_ADDR_LAMP_CFG;
			wr_data_reg <= LGPS_WORD_ZERO;
			wr_strb_reg <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held_reg <= 1'b1;
				wr_addr_reg <= s_axi_awaddr;
			end
			else if (wr_go)
				aw_held_reg <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held_reg  <= 1'b1;
				wr_data_reg <= s_axi_wdata;
				wr_strb_reg <= s_axi_wstrb;
			end
			else if (wr_go)
				w_held_reg <= 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= LGPS_RESP_OKAY;
		end
		else
		begin
			s_axi_awready <= !aw_held_reg && !(s_axi_awvalid && s_axi_awready) && !wr_go;
			s_axi_wready  <= !w_held_reg && !(s_axi_wvalid && s_axi_wready) && !wr_go;
			if (wr_go)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_hit ? LGPS_RESP_OKAY : LGPS_RESP_SLVERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// ==========================================================
	// control registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			lamp_en_reg                <= 1'b0;
			lamp_driver_function_field <= LGPS_FUN_RESET;
			gpio_od_reg                <= 1'b0;
			gpio_data_reg              <= 1'b0;
			gpio_dir_reg               <= 1'b0;
		end
		else if (wr_go)
		begin
			if (wr_addr_reg == LGPS_ADDR_LAMP_CFG && wr_strb_reg[0])
				lamp_en_reg <= wr_data_reg[LGPS_LAMP1_EN_BIT];
			if (wr_addr_reg == LGPS_ADDR_LAMP_CFG && wr_strb_reg[1])
				lamp_driver_function_field <= wr_data_reg[LGPS_LAMP_FUN_LSB +: 2];
			if (wr_addr_reg == LGPS_ADDR_GPIO_CFG && wr_strb_reg[0])
				gpio_od_reg <= wr_data_reg[LGPS_GENERAL_IO_PIN_1_OD_BIT];
			if (wr_addr_reg == LGPS_ADDR_GPIO_DATA && wr_strb_reg[0])
				gpio_data_reg <= wr_data_reg[LGPS_GENERAL_IO_PIN_1_DATA_BIT];
			if (wr_addr_reg == LGPS_ADDR_GPIO_DATA && wr_strb_reg[1])
				gpio_dir_reg <= wr_data_reg[LGPS_GENERAL_IO_PIN_1_DIR_BIT];
		end
	end

	// soft-strap takes the captured strap as its default
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			port2_crossover_enable <= pin_sync_reg;
		else if (strap_override_valid)
			port2_crossover_enable <= strap_override_value;
		else if (wr_go && wr_addr_reg == LGPS_ADDR_XOVER && wr_strb_reg[0])
			port2_crossover_enable <= wr_data_reg[LGPS_XOVER_EN_BIT];
	end

	// ==========================================================
	// read channel
	always_comb
	begin
		rd_word = LGPS_WORD_ZERO;
		rd_hit  = 1'b1;
		unique case (s_axi_araddr)
			LGPS_ADDR_LAMP_CFG:
			begin
				rd_word[LGPS_LAMP1_EN_BIT]        = lamp_en_reg;
				rd_word[LGPS_LAMP_FUN_LSB +: 2]   = lamp_driver_function_field;
			end
			LGPS_ADDR_GPIO_CFG:
				rd_word[LGPS_GENERAL_IO_PIN_1_OD_BIT]        = gpio_od_reg;
			LGPS_ADDR_GPIO_DATA:
			begin
				rd_word[LGPS_GENERAL_IO_PIN_1_DATA_BIT]      = gpio_dir_reg ? gpio_data_reg : pin_sync_reg;
				rd_word[LGPS_GENERAL_IO_PIN_1_DIR_BIT]       = gpio_dir_reg;
			end
			LGPS_ADDR_STATUS:
			begin
				rd_word[LGPS_STAT_STRAP_BIT]      = port2_crossover_polarity_strap;
				rd_word[LGPS_STAT_PIN_BIT]        = pin_sync_reg;
				rd_word[LGPS_STAT_MODE_BIT]       = lamp_en_reg;
			end
			LGPS_ADDR_XOVER:
				rd_word[LGPS_XOVER_EN_BIT]        = port2_crossover_enable;
			default:
				rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= LGPS_WORD_ZERO;
			s_axi_rresp   <= LGPS_RESP_OKAY;
		end
		else
		begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_word;
				s_axi_rresp  <= rd_hit ? LGPS_RESP_OKAY : LGPS_RESP_SLVERR;
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// ==========================================================
	// pin output stage
	lgps_pin_driver u_driver (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.lamp_mode (lamp_en_reg),
		.lamp_fun  (lamp_driver_function_field),
		.strap     (port2_crossover_polarity_strap),
		.lamp_on   (lamp_activity),
		.gpio_dir  (gpio_dir_reg),
		.gpio_od   (gpio_od_reg),
		.gpio_data (gpio_data_reg),
		.pin_out   (status_lamp_pin_1_out),
		.pin_oe    (status_lamp_pin_1_oe)
	);

	// ==========================================================
	// checks
	wire open_lamp = lamp_en_reg && lamp_driver_function_field != LGPS_FUN_PUSH_PULL;

	sequence s_reset_release;
		!aresetn ##1 aresetn;
	endsequence

	property p_lamp_push;
		@(posedge aclk) disable iff (!aresetn)
		lamp_en_reg && lamp_driver_function_field == LGPS_FUN_PUSH_PULL
		|=> status_lamp_pin_1_oe && status_lamp_pin_1_out == $past(lamp_activity);
	endproperty
	a_lamp_push: assert property (p_lamp_push) else $error("lamp push-pull drive wrong");

	property p_gpio_push;
		@(posedge aclk) disable iff (!aresetn)
		!lamp_en_reg && gpio_dir_reg && !gpio_od_reg
		|=> status_lamp_pin_1_oe && status_lamp_pin_1_out == $past(gpio_data_reg);
	endproperty
	a_gpio_push: assert property (p_gpio_push) else $error("gpio push-pull drive wrong");

	property p_gpio_od;
		@(posedge aclk) disable iff (!aresetn)
		!lamp_en_reg && gpio_dir_reg && gpio_od_reg
		|=> !status_lamp_pin_1_out && status_lamp_pin_1_oe == !$past(gpio_data_reg);
	endproperty
	a_gpio_od: assert property (p_gpio_od) else $error("gpio open-drain drive wrong");

	property p_gpio_in;
		@(posedge aclk) disable iff (!aresetn)
		!lamp_en_reg && !gpio_dir_reg |=> !status_lamp_pin_1_oe;
	endproperty
	a_gpio_in: assert property (p_gpio_in) else $error("gpio input still drives");

	property p_open_polarity;
		@(posedge aclk) disable iff (!aresetn)
		open_lamp |=> status_lamp_pin_1_oe == $past(lamp_activity)
			&& status_lamp_pin_1_out == !$past(port2_crossover_polarity_strap);
	endproperty
	a_open_polarity: assert property (p_open_polarity) else $error("open lamp polarity wrong");

	property p_strap_frozen;
		@(posedge aclk) disable iff (!aresetn)
		!strap_override_valid |=> $stable(port2_crossover_polarity_strap);
	endproperty
	a_strap_frozen: assert property (p_strap_frozen) else $error("strap changed after reset");

	// no disable iff here: the antecedent starts inside reset on purpose
	property p_strap_capture;
		@(posedge aclk)
		s_reset_release |-> port2_crossover_polarity_strap == $past(pin_sync_reg)
			&& !status_lamp_pin_1_oe;
	endproperty
	a_strap_capture: assert property (p_strap_capture) else $error("strap not caught at reset");

	property p_xover_default;
		@(posedge aclk)
		s_reset_release |-> port2_crossover_enable == port2_crossover_polarity_strap;
	endproperty
	a_xover_default: assert property (p_xover_default) else $error("crossover default wrong");

	property p_override;
		@(posedge aclk) disable iff (!aresetn)
		strap_override_valid |=> port2_crossover_polarity_strap == $past(strap_override_value);
	endproperty
	a_override: assert property (p_override) else $error("strap override lost");

endmodule : lgps_pin_select

/* dv/lgps_board_model.sv */
// board side of the shared pin: pull resistor and pad level
`timescale 1ns/1ps
module lgps_board_model
	import lgps_pkg::*;
(
	input  wire logic pin_out,  // driven value from the block
	input  wire logic pin_oe,   // high while the block drives the pad
	input  wire logic pull_up,  // board pull level, also the strap
	output logic      pad       // level seen on the pad
);
	// ==========================================================
	// released pad falls to the pull level
	assign pad = pin_oe ? pin_out : pull_up;
endmodule : lgps_board_model

/* dv/test_lamp_gpio_pin_select.sv */
// register level test of the lamp / general-purpose pin select
`timescale 1ns/1ps
module test_lamp_gpio_pin_select;
	import lgps_pkg::*;
	logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic awready, wready, bvalid, arready, rvalid, oe, out, pad, xo;
	logic [7:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, d;
	logic [3:0] wstrb = 4'hF;
	logic [1:0] bresp, rresp;
	logic act = 0, ovr = 0, ovr_val = 0, pull = 1;
	int errors = 0, samples_checked = 0, cycles = 0;

	// ==========================================================
	// design and board
	lgps_pin_select dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .lamp_activity(act),
		.strap_override_valid(ovr), .strap_override_value(ovr_val), .status_lamp_pin_1_in(pad),
		.status_lamp_pin_1_out(out), .status_lamp_pin_1_oe(oe), .port2_crossover_enable(xo));
	lgps_board_model board (.pin_out(out), .pin_oe(oe), .pull_up(pull), .pad(pad));

	always #2.5 aclk = ~aclk;

	// ==========================================================
	// hang guard
	always @(posedge aclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			errors = errors + 1;
			final_report();
		end
	end

	task automatic final_report();
		$display("checked %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : final_report

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked = samples_checked + 1;
		if (g !== e)
		begin
			errors = errors + 1;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	// ==========================================================
	// bus cycles, entered just after a rising edge
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		logic aw, w;
		aw = 1;
		w = 1;
		awaddr <= a;
		wdata <= v;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		while (aw || w)
		begin
			@(posedge aclk);
			if (aw && awready === 1'b1)
			begin
				aw = 0;
				awvalid <= 0;
			end
			if (w && wready === 1'b1)
			begin
				w = 0;
				wvalid <= 0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		bready <= 0;
		chk("bresp", {30'h0, er}, {30'h0, bresp});
		@(posedge aclk);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		v = rdata;
		rready <= 0;
		chk("rresp", {30'h0, er}, {30'h0, rresp});
		@(posedge aclk);
	endtask : rd

	task automatic pin(input logic e, input logic o);
		repeat (3) @(posedge aclk);
		chk("pin_oe", {31'h0, e}, {31'h0, oe});
		if (e)
			chk("pin_out", {31'h0, o}, {31'h0, out});
	endtask : pin

	task automatic rst(input logic p);
		pull <= p;
		aresetn <= 0;
		repeat (16) @(posedge aclk);
		chk("oe_in_reset", 32'h0000_0000, {31'h0, oe});
		aresetn <= 1;
		repeat (2) @(posedge aclk);
	endtask : rst

	// ==========================================================
	// test sequence
	initial
	begin
		@(posedge aclk);
		rst(1);
		rd(LGPS_ADDR_STATUS, d, LGPS_RESP_OKAY);
		chk("strap", 32'h0000_0003, d & 32'h0000_0007);
		chk("xover_out", 32'h0000_0001, {31'h0, xo});
		rd(LGPS_ADDR_XOVER, d, LGPS_RESP_OKAY);
		chk("xover_reg", 32'h0000_0001, d & 32'h0000_0001);
		rd(LGPS_ADDR_GPIO_DATA, d, LGPS_RESP_OKAY);
		chk("gpio_in", 32'h0000_0002, d & 32'h0000_0002);
		pin(0, 0);
		wr(LGPS_ADDR_GPIO_DATA, 32'h0000_0202, LGPS_RESP_OKAY);
		pin(1, 1);
		wr(LGPS_ADDR_GPIO_DATA, 32'h0000_0200, LGPS_RESP_OKAY);
		pin(1, 0);
		wr(LGPS_ADDR_GPIO_CFG, 32'h0000_0002, LGPS_RESP_OKAY);
		pin(1, 0);
		wr(LGPS_ADDR_GPIO_DATA, 32'h0000_0202, LGPS_RESP_OKAY);
		pin(0, 0);
		act <= 1;
		wr(LGPS_ADDR_LAMP_CFG, 32'h0000_0002, LGPS_RESP_OKAY);
		pin(1, 1);
		act <= 0;
		pin(1, 0);
		rd(LGPS_ADDR_STATUS, d, LGPS_RESP_OKAY);
		chk("lamp_mode", 32'h0000_0004, d & 32'h0000_0004);
		wr(LGPS_ADDR_XOVER, 32'h0000_0000, LGPS_RESP_OKAY);
		chk("xover_sw", 32'h0000_0000, {31'h0, xo});
		for (int f = 1; f < 4; f++)
		begin
			wr(LGPS_ADDR_LAMP_CFG, (f << 8) | 32'h0000_0002, LGPS_RESP_OKAY);
			act <= 1;
			pin(1, 0);
			act <= 0;
			pin(0, 0);
		end
		rd(LGPS_ADDR_LAMP_CFG, d, LGPS_RESP_OKAY);
		chk("lamp_cfg", 32'h0000_0302, d);
		ovr_val <= 0;
		ovr <= 1;
		@(posedge aclk);
		ovr <= 0;
		act <= 1;
		pin(1, 1);
		rd(LGPS_ADDR_STATUS, d, LGPS_RESP_OKAY);
		chk("strap_ovr", 32'h0000_0000, d & 32'h0000_0001);
		wr(LGPS_ADDR_LAMP_CFG, 32'h0000_0000, LGPS_RESP_OKAY);
		pin(0, 0);
		wr(8'h20, 32'h0000_0002, LGPS_RESP_SLVERR);
		rd(8'h20, d, LGPS_RESP_SLVERR);
		chk("unmapped", LGPS_WORD_ZERO, d);
		rst(0);
		chk("xover_low", 32'h0000_0000, {31'h0, xo});
		rd(LGPS_ADDR_STATUS, d, LGPS_RESP_OKAY);
		chk("strap_low", 32'h0000_0000, d & 32'h0000_0001);
		rd(LGPS_ADDR_GPIO_DATA, d, LGPS_RESP_OKAY);
		chk("gpio_in_low", 32'h0000_0000, d & 32'h0000_0002);
		final_report();
	end
endmodule : test_lamp_gpio_pin_select
